//--- verilog/flash_cfg.svh
// constants for the serial flash status-write and read engine
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH
// ************************************************
// instruction codes
// ************************************************
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_VWREN 8'h50
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_READ 8'h03
`define OP_FREAD 8'h0B
`define OP_FREAD2 8'h3B
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
// ************************************************
// status field layout and reset values
// ************************************************
`define SR1_WR_MASK 8'h7C
`define SR2_WR_MASK 8'h7B
`define SR3_WR_MASK 8'h64
`define SR2_OTP_MASK 8'h38
`define SR2_LOCK_MASK 8'h01
`define SR1_BUSY_BIT 0
`define SR1_WEL_BIT 1
`define SR1_RST 8'h00
`define SR2_RST 8'h00
`define SR3_RST 8'h60
// ************************************************
// sizes and timing
// ************************************************
`define ADDR_BITS 24
`define DUMMY_CLKS 8
`define CLK_PERIOD_NS 10
`define NV_STATUS_CYCLE_NS 10000000
`endif

//--- verilog/flash_pkg.sv
// types shared by the serial flash engine
package flash_pkg;
  typedef struct packed {
    logic [7:0] sr3;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } status_set_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_WDATA, ST_SROUT, ST_RDOUT, ST_SKIP
  } spi_state_t;
endpackage : flash_pkg

//--- verilog/pair_buffer.sv
// small fifo between the array read port and the output shifter
module pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_idx;
  logic [PW-1:0] rd_idx;
  logic [LW-1:0] count;
  logic [LW-1:0] next_count;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] idx);
    step = (32'(idx) == DEPTH - 1) ? '0 : idx + 1'b1;
  endfunction : step

  assign out_valid_o = (count != '0);
  assign out_data_o = store[rd_idx];
  assign level_o = count;
  assign next_count = count + LW'(push) - LW'(pop);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && flush_i))
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        store[wr_idx] <= in_data_i;
        wr_idx <= step(wr_idx);
      end
      if (pop)
        rd_idx <= step(rd_idx);
      count <= next_count;
      // registered so a stalled shifter back-pressures the array port
      in_ready_o <= (32'(next_count) < DEPTH);
    end
  end
endmodule : pair_buffer

//--- verilog/flash_status_read_engine.sv
// serial flash instruction engine: status writes and single/dual reads
// ************************************************
// Overview of operation
// - only the listed writable bits of the three status registers change
// - otp lock bits once set to one never return to zero
// - status write is opcode 01h, 31h or 11h then one data byte, or two data bytes after 01h
// - non-volatile status write accepted only with write enable latch set
// - after 50h a status write goes to volatile bits, latch stays zero
// - volatile write cannot clear status lock or otp lock bits
// - any reset drops volatile values and reloads the non-volatile ones
// - non-volatile write runs a self-timed cycle with busy set
// - status reads still work during the non-volatile cycle
// - write enable latch clears when the non-volatile cycle ends
// - volatile write applies promptly after chip select rises, busy stays zero
// - 01h with two data bytes writes registers one and two
// - 01h with one data byte writes register one only
// - read 03h takes a 24-bit address sampled on rising clock
// - data shifts out msb first, changing on falling clock
// - read address increments after every byte, streaming forever
// - plain read while busy is ignored without disturbing the cycle
// - plain read only recognised in single-lane mode
// - fast read 0Bh inserts eight dummy clocks before data
// - dual fast read 3Bh outputs data on both lanes
// - dual byte order: lane1 carries 7,5,3,1 and lane0 carries 6,4,2,0
// - 06h sets the write enable latch
// ************************************************
`include "flash_cfg.svh"
module flash_status_read_engine #(
  parameter int ADDR_W = `ADDR_BITS,
  parameter int NV_CYCLES = `NV_STATUS_CYCLE_NS / `CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_pin_i,
  input wire logic hw_reset_n_i,
  input wire logic array_busy_i,
  output logic lane0_pin_o,
  output logic lane0_pin_oe_o,
  output logic lane1_pin_o,
  output logic lane1_pin_oe_o,
  output logic mem_req_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  input wire logic mem_valid_i,
  output logic mem_ready_o,
  output flash_pkg::status_set_t status_o
);
  import flash_pkg::*;
  localparam int TW = $clog2(NV_CYCLES + 1);

  // ************************************************
  // pin synchronisers and edge detect
  // ************************************************
  logic [3:0] meta;
  logic [3:0] sync;
  logic sclk_d;
  logic cs_d;
  wire cs_n = sync[0];
  wire din = sync[2];
  wire hw_rst = ~sync[3];
  wire sclk_rise = sync[1] & ~sclk_d & ~cs_n;
  wire sclk_fall = ~sync[1] & sclk_d & ~cs_n;
  wire cs_rise = cs_n & ~cs_d;
  wire cs_fall = ~cs_n & cs_d;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta <= 4'h9;
      sync <= 4'h9;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else if (clk_en_i)
    begin
      meta <= {hw_reset_n_i, serial_in_pin_i, serial_clk_i, chip_sel_n_i};
      sync <= meta;
      sclk_d <= sync[1];
      cs_d <= sync[0];
    end
  end

  // ************************************************
  // state
  // ************************************************
  spi_state_t state;
  logic [7:0] opcode;
  logic [23:0] in_sr;
  logic [4:0] bitcnt;
  logic [4:0] wbits;
  logic skip_extra;
  logic [7:0] nv1, nv2, nv3;
  logic [7:0] vol1, vol2, vol3;
  logic write_enable_latch;
  logic vol_arm;
  logic rst_arm;
  logic nv_busy;
  logic [TW-1:0] nv_cnt;
  logic [7:0] out_sr;
  logic [2:0] bits_left;
  logic fetch_on;
  logic pending;
  logic [ADDR_W-1:0] fetch_addr;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] wmask, input logic [7:0] keep);
    merge = (old & ~wmask) | (d & wmask) | (old & keep);
  endfunction : merge

  function automatic logic [7:0] sr_of(input logic [7:0] op, input status_set_t s);
    sr_of = (op == `OP_RDSR2) ? s.sr2 : (op == `OP_RDSR3) ? s.sr3 : s.sr1;
  endfunction : sr_of

  // ************************************************
  // decode
  // ************************************************
  wire busy = nv_busy | array_busy_i;
  wire [7:0] op_byte = {in_sr[6:0], din};
  wire op_done = sclk_rise && state == ST_OP && bitcnt == 5'd7;
  wire is_rdsr = op_byte == `OP_RDSR1 || op_byte == `OP_RDSR2 || op_byte == `OP_RDSR3;
  // only single-lane opcodes are decoded here, so 03h is never seen in wider modes
  wire is_read = op_byte == `OP_READ || op_byte == `OP_FREAD || op_byte == `OP_FREAD2;
  wire is_wrsr = op_byte == `OP_WRSR1 || op_byte == `OP_WRSR2 || op_byte == `OP_WRSR3;
  wire wr_ok = (write_enable_latch || vol_arm) && !busy;
  wire dual = opcode == `OP_FREAD2;
  wire addr_done = sclk_rise && state == ST_ADDR && 32'(bitcnt) == ADDR_W - 1;
  wire dummy_done = sclk_rise && state == ST_DUMMY && 32'(bitcnt) == `DUMMY_CLKS - 1;
  wire exec = cs_rise && state == ST_SKIP && !skip_extra;
  wire exec_vwren = exec && opcode == `OP_VWREN;
  wire soft_rst = exec && opcode == `OP_RST && rst_arm;
  wire any_rst = hw_rst | soft_rst;
  wire wr_two = wbits == 5'd16 && opcode == `OP_WRSR1;
  wire wr_one = wbits == 5'd8;
  wire wr_go = cs_rise && state == ST_WDATA && (wr_one || wr_two);
  wire wr_nv = wr_go && write_enable_latch;
  wire wr_vol = wr_go && !write_enable_latch && vol_arm;
  wire [7:0] b1 = wr_two ? in_sr[15:8] : in_sr[7:0];
  wire tgt1 = opcode == `OP_WRSR1;
  wire tgt2 = opcode == `OP_WRSR2 || wr_two;
  wire tgt3 = opcode == `OP_WRSR3;
  // only writable bits move, otp bits never clear
  wire [7:0] nv1_new = merge(nv1, b1, `SR1_WR_MASK, 8'h00);
  wire [7:0] nv2_new = merge(nv2, in_sr[7:0], `SR2_WR_MASK, `SR2_OTP_MASK);
  wire [7:0] nv3_new = merge(nv3, in_sr[7:0], `SR3_WR_MASK, 8'h00);
  wire [7:0] vol1_new = merge(vol1, b1, `SR1_WR_MASK, 8'h00);
  wire [7:0] vol2_new = merge(vol2, in_sr[7:0], `SR2_WR_MASK,
                              `SR2_OTP_MASK | `SR2_LOCK_MASK);
  wire [7:0] vol3_new = merge(vol3, in_sr[7:0], `SR3_WR_MASK, 8'h00);
  wire [7:0] sr1_live = {vol1[7:2], write_enable_latch, busy};
  wire buf_valid;
  wire [7:0] buf_data;
  wire [1:0] buf_level;
  wire [7:0] load_byte = (state == ST_SROUT) ? sr_of(opcode, status_o) :
                         (buf_valid ? buf_data : 8'hFF);
  wire load_now = sclk_fall && (state == ST_SROUT || state == ST_RDOUT) && bits_left == 3'd0;
  wire pop = load_now && state == ST_RDOUT;
  // first fetch leaves on the last address edge: the byte must be buffered by the next fall
  wire fetch_go = (fetch_on || addr_done) && !pending && !mem_req_o && buf_level < 2'd2;
  wire [ADDR_W-1:0] next_fetch = addr_done ? {in_sr[ADDR_W-2:0], din} : fetch_addr;

  // ************************************************
  // instruction sequencer
  // ************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || (clk_en_i && (any_rst || cs_rise)))
      state <= ST_IDLE;
    else if (clk_en_i)
    begin
      if (cs_fall)
      begin
        state <= ST_OP;
        bitcnt <= '0;
        wbits <= '0;
        skip_extra <= 1'b0;
      end
      else if (sclk_rise)
      begin
        in_sr <= {in_sr[22:0], din};
        bitcnt <= bitcnt + 5'd1;
        case (state)
          ST_OP:
            if (bitcnt == 5'd7)
            begin
              opcode <= op_byte;
              bitcnt <= '0;
              if (is_rdsr)
                state <= ST_SROUT;
              else if (is_read && !busy)
                state <= ST_ADDR;
              else if (is_wrsr && wr_ok)
                state <= ST_WDATA;
              else
                state <= ST_SKIP;
            end
          ST_ADDR:
            if (addr_done)
            begin
              bitcnt <= '0;
              state <= (opcode == `OP_READ) ? ST_RDOUT : ST_DUMMY;
            end
          ST_DUMMY:
            if (dummy_done)
              state <= ST_RDOUT;
          ST_WDATA:
            if (wbits != 5'd17)
              wbits <= wbits + 5'd1;
          ST_SKIP:
            skip_extra <= 1'b1;
          default:
            ;
        endcase
      end
    end
  end

  // ************************************************
  // status registers, latches and write cycle
  // ************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      {nv1, nv2, nv3} <= {`SR1_RST, `SR2_RST, `SR3_RST};
      {vol1, vol2, vol3} <= {`SR1_RST, `SR2_RST, `SR3_RST};
      {write_enable_latch, vol_arm, rst_arm, nv_busy} <= 4'h0;
      nv_cnt <= '0;
    end
    else if (clk_en_i)
    begin
      if (cs_rise)
      begin
        vol_arm <= exec_vwren && !busy;
        rst_arm <= exec && opcode == `OP_RSTEN;
      end
      if (exec && opcode == `OP_WREN && !nv_busy)
        write_enable_latch <= 1'b1;
      if (exec && opcode == `OP_WRDI && !nv_busy)
        write_enable_latch <= 1'b0;
      if (wr_nv)
      begin
        nv_busy <= 1'b1;
        nv_cnt <= TW'(NV_CYCLES);
        if (tgt1)
          {nv1, vol1} <= {nv1_new, nv1_new};
        if (tgt2)
          {nv2, vol2} <= {nv2_new, nv2_new};
        if (tgt3)
          {nv3, vol3} <= {nv3_new, nv3_new};
      end
      else if (nv_busy)
      begin
        nv_cnt <= nv_cnt - 1'b1;
        if (nv_cnt == TW'(1))
        begin
          nv_busy <= 1'b0;
          write_enable_latch <= 1'b0;
        end
      end
      // volatile copy lands the cycle after chip select is seen high
      if (wr_vol)
      begin
        if (tgt1)
          vol1 <= vol1_new;
        if (tgt2)
          vol2 <= vol2_new;
        if (tgt3)
          vol3 <= vol3_new;
      end
      if (any_rst)
      begin
        {vol1, vol2, vol3} <= {nv1, nv2, nv3};
        {write_enable_latch, vol_arm, rst_arm} <= 3'h0;
      end
    end
  end

  // ************************************************
  // output shifter
  // ************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || (clk_en_i && (cs_n || any_rst)))
    begin
      {lane0_pin_o, lane0_pin_oe_o, lane1_pin_o, lane1_pin_oe_o} <= 4'h0;
      out_sr <= '0;
      bits_left <= '0;
    end
    else if (clk_en_i && sclk_fall && (state == ST_SROUT || state == ST_RDOUT))
    begin
      lane1_pin_oe_o <= 1'b1;
      lane0_pin_oe_o <= dual;
      if (load_now && dual)
      begin
        {lane1_pin_o, lane0_pin_o} <= load_byte[7:6];
        out_sr <= {load_byte[5:0], 2'b00};
        bits_left <= 3'd3;
      end
      else if (load_now)
      begin
        lane1_pin_o <= load_byte[7];
        out_sr <= {load_byte[6:0], 1'b0};
        bits_left <= 3'd7;
      end
      else if (dual)
      begin
        {lane1_pin_o, lane0_pin_o} <= out_sr[7:6];
        out_sr <= {out_sr[5:0], 2'b00};
        bits_left <= bits_left - 3'd1;
      end
      else
      begin
        lane1_pin_o <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
        bits_left <= bits_left - 3'd1;
      end
    end
  end

  // ************************************************
  // array fetch and status mirror
  // ************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      {fetch_on, pending, mem_req_o} <= 3'h0;
      fetch_addr <= '0;
      mem_addr_o <= '0;
      status_o <= '0;
    end
    else if (clk_en_i)
    begin
      status_o <= {vol3, vol2, sr1_live};
      mem_req_o <= fetch_go;
      if (addr_done)
        fetch_addr <= next_fetch;
      if (cs_rise || any_rst)
        fetch_on <= 1'b0;
      else if (addr_done)
        fetch_on <= 1'b1;
      if (fetch_go)
      begin
        mem_addr_o <= next_fetch;
        fetch_addr <= next_fetch + 1'b1;
        pending <= 1'b1;
      end
      else if (mem_valid_i && mem_ready_o)
        pending <= 1'b0;
    end
  end

  // late answers after chip select rises are accepted and dropped
  pair_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_buf (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .ce_i(clk_en_i),
    .flush_i(cs_rise || any_rst),
    .in_valid_i(mem_valid_i && fetch_on),
    .in_data_i(mem_data_i),
    .in_ready_o(mem_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(pop),
    .level_o(buf_level)
  );
endmodule : flash_status_read_engine

//--- tb/flash_status_read_engine_asserts.sv
// port-level assertion checker for the flash instruction engine
module flash_status_read_engine_asserts
  import flash_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int NV_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic chip_sel_n_i,
  input wire logic array_busy_i,
  input wire logic lane0_pin_oe_o,
  input wire logic lane1_pin_oe_o,
  input wire logic mem_req_o,
  input flash_pkg::status_set_t status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_run;
  logic arr_in_run;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ********
  // busy run length helper
  // ********
  // runs raised by the array busy input are excluded from the length check
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !status_o.sr1[0])
    begin
      busy_run <= 32'h0;
      arr_in_run <= 1'b0;
    end
    else
    begin
      busy_run <= busy_run + 32'h1;
      arr_in_run <= arr_in_run | array_busy_i;
    end
  end
  sequence s_cs_idle;
    chip_sel_n_i [*4];
  endsequence
  sequence s_busy_end;
    $fell(status_o.sr1[0]) ##0 !arr_in_run;
  endsequence
  property p_oe_release;
    s_cs_idle |-> !lane1_pin_oe_o && !lane0_pin_oe_o;
  endproperty
  property p_lane0_dual;
    lane0_pin_oe_o |-> lane1_pin_oe_o;
  endproperty
  property p_no_fetch_busy;
    mem_req_o |-> !status_o.sr1[0];
  endproperty
  property p_array_busy;
    $rose(array_busy_i) |-> ##[1:2] status_o.sr1[0];
  endproperty
  property p_busy_len;
    s_busy_end |-> busy_run >= NV_CYCLES - 1 && busy_run <= NV_CYCLES + 1;
  endproperty
  property p_wel_clear;
    s_busy_end |-> !status_o.sr1[1];
  endproperty
  property p_wel_set;
    $rose(status_o.sr1[1]) |-> chip_sel_n_i && $past(chip_sel_n_i) && $past(chip_sel_n_i, 2);
  endproperty
  property p_fixed_bits;
    !status_o.sr1[7] && (status_o.sr2 & 8'h84) == 8'h00 && (status_o.sr3 & 8'h9B) == 8'h00;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("lane enable still high with chip select idle");
  a_lane0_dual: assert property (p_lane0_dual)
    else $error("lane0 driven outside a dual data phase");
  a_no_fetch_busy: assert property (p_no_fetch_busy)
    else $error("array fetch while busy");
  a_array_busy: assert property (p_array_busy)
    else $error("array busy not shown in busy flag");
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  a_wel_clear: assert property (p_wel_clear)
    else $error("write enable latch left set after write cycle");
  a_wel_set: assert property (p_wel_set)
    else $error("write enable latch set inside a frame");
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("read-only status bit changed");
endmodule : flash_status_read_engine_asserts

bind flash_status_read_engine flash_status_read_engine_asserts #(
  .ADDR_W(ADDR_W),
  .NV_CYCLES(NV_CYCLES)
) chk_u (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .chip_sel_n_i(chip_sel_n_i),
  .array_busy_i(array_busy_i),
  .lane0_pin_oe_o(lane0_pin_oe_o),
  .lane1_pin_oe_o(lane1_pin_oe_o),
  .mem_req_o(mem_req_o),
  .status_o(status_o)
);

//--- tb/spi_host_model.sv
// host side spi controller model, mode 0, serial clock only within frames
module spi_host_model (
  input wire logic lane0_i,
  input wire logic lane1_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // ********
  // one frame
  // ********
  // lanes are read just before each falling edge, where device data stands
  task automatic xfer(input logic [63:0] tx, input int n_tx, input int n_cyc,
                      output logic [63:0] rx1, output logic [63:0] rx0);
    rx1 = 64'h0;
    rx0 = 64'h0;
    #3;
    cs_n_o = 1'b0;
    for (int c = 0; c < n_cyc; c++)
    begin
      // released lane toggles so no stale level can pass for data
      mosi_o = (c < n_tx) ? tx[63 - c] : ~mosi_o;
      #40;
      sclk_o = 1'b1;
      #39;
      rx1 = {rx1[62:0], lane1_i};
      rx0 = {rx0[62:0], lane0_i};
      #1;
      sclk_o = 1'b0;
    end
    #40;
    cs_n_o = 1'b1;
    #300;
  endtask : xfer
endmodule : spi_host_model

//--- tb/flash_status_read_engine_tb.sv
// self-checking bench for the flash instruction engine
`include "flash_cfg.svh"
module flash_status_read_engine_tb
  import flash_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV_CYC = 800;
  logic ref_clk_i, sys_rst_i, clk_en_i, hw_reset_n_i, array_busy_i, mem_valid_i;
  logic [7:0] mem_data_i;
  logic cs_n, sclk, mosi, lane0_w, lane1_w, oe_seen;
  logic lane0_pin_o, lane0_pin_oe_o, lane1_pin_o, lane1_pin_oe_o, mem_req_o, mem_ready_o;
  logic [23:0] mem_addr_o;
  status_set_t status_o;
  logic [63:0] rx1, rx0;
  int n_mismatch, check_count, cycle_cnt;
  assign lane0_w = lane0_pin_oe_o ? lane0_pin_o : mosi;
  assign lane1_w = lane1_pin_oe_o ? lane1_pin_o : 1'bz;
  flash_status_read_engine #(.NV_CYCLES(NV_CYC)) dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .chip_sel_n_i(cs_n), .serial_clk_i(sclk), .serial_in_pin_i(lane0_w),
    .hw_reset_n_i(hw_reset_n_i), .array_busy_i(array_busy_i),
    .lane0_pin_o(lane0_pin_o), .lane0_pin_oe_o(lane0_pin_oe_o),
    .lane1_pin_o(lane1_pin_o), .lane1_pin_oe_o(lane1_pin_oe_o),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
    .mem_valid_i(mem_valid_i), .mem_ready_o(mem_ready_o), .status_o(status_o)
  );
  spi_host_model host_u (
    .lane0_i(lane0_w), .lane1_i(lane1_w), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi)
  );
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : pat
  function automatic logic [3:0] odd_bits(input logic [7:0] b);
    return {b[7], b[5], b[3], b[1]};
  endfunction : odd_bits
  function automatic logic [3:0] even_bits(input logic [7:0] b);
    return {b[6], b[4], b[2], b[0]};
  endfunction : even_bits
  task automatic stop_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // ********
  // array model and run limit
  // ********
  // answers one cycle after the request and holds until the buffer takes it
  always @(posedge ref_clk_i)
  begin
    if (mem_req_o)
    begin
      mem_valid_i <= 1'b1;
      mem_data_i <= pat(mem_addr_o);
    end
    else if (mem_ready_o)
      mem_valid_i <= 1'b0;
    if (lane1_pin_oe_o)
      oe_seen <= 1'b1;
    cycle_cnt++;
    if (cycle_cnt == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [63:0] tx, input int n_tx, input int n_cyc);
    host_u.xfer(tx, n_tx, n_cyc, rx1, rx0);
  endtask : frame
  task automatic cmd(input logic [7:0] op);
    frame({op, 56'h0}, 8, 8);
  endtask : cmd
  task automatic wr(input logic [7:0] op, input logic [15:0] d, input int nbits);
    frame({op, d, 40'h0}, 8 + nbits, 8 + nbits);
  endtask : wr
  task automatic wait_idle;
    for (int i = 0; i < 2000 && status_o.sr1[0] !== 1'b0; i++)
      @(posedge ref_clk_i);
    chk(status_o.sr1[0], 1'b0);
  endtask : wait_idle
  // ********
  // main sequence
  // ********
  initial
  begin
    sys_rst_i = 1'b1;
    clk_en_i = 1'b1;
    hw_reset_n_i = 1'b1;
    array_busy_i = 1'b0;
    mem_valid_i = 1'b0;
    mem_data_i = 8'h00;
    oe_seen = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    cycle_cnt = 0;
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(status_o, 24'h600000);
    wr(`OP_WRSR1, 16'h7C00, 8);
    chk(status_o.sr1, 8'h00);
    cmd(`OP_WREN);
    chk(status_o.sr1, 8'h02);
    wr(`OP_WRSR1, 16'hFFFF, 16);
    chk(status_o.sr1[0], 1'b1);
    frame({`OP_RDSR1, 56'h0}, 8, 16);
    chk(rx1[0], 1'b1);
    oe_seen <= 1'b0;
    frame({`OP_READ, 56'h0}, 32, 40);
    chk(oe_seen, 1'b0);
    wait_idle();
    chk(status_o[15:0], 16'h7B7C);
    cmd(`OP_VWREN);
    wr(`OP_WRSR2, 16'h0000, 8);
    chk(status_o[15:0], 16'h397C);
    cmd(`OP_WREN);
    wr(`OP_WRSR2, 16'h0000, 8);
    wait_idle();
    chk(status_o.sr2, 8'h38);
    cmd(`OP_WREN);
    wr(`OP_WRSR1, 16'h0000, 8);
    wait_idle();
    chk(status_o[15:0], 16'h3800);
    for (int k = 0; k < 2; k++)
    begin
      cmd(`OP_VWREN);
      wr(`OP_WRSR3, 16'h0000, 8);
      chk(status_o.sr3, 8'h00);
      if (k == 0)
      begin
        @(posedge ref_clk_i);
        hw_reset_n_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        hw_reset_n_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
      end
      else
      begin
        cmd(`OP_RSTEN);
        cmd(`OP_RST);
      end
      chk(status_o.sr3, 8'h60);
    end
    @(posedge ref_clk_i);
    array_busy_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(status_o.sr1[0], 1'b1);
    oe_seen <= 1'b0;
    frame({`OP_READ, 56'h0}, 32, 40);
    chk(oe_seen, 1'b0);
    @(posedge ref_clk_i);
    array_busy_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    frame({`OP_READ, 24'h0000FE, 32'h0}, 32, 56);
    chk(rx1[23:0], {pat(24'h0000FE), pat(24'h0000FF), pat(24'h000100)});
    frame({`OP_FREAD, 24'h123456, 32'h0}, 32, 56);
    chk(rx1[15:0], {pat(24'h123456), pat(24'h123457)});
    frame({`OP_FREAD2, 24'h00ABCD, 32'h0}, 32, 48);
    chk(rx1[7:0], {odd_bits(pat(24'h00ABCD)), odd_bits(pat(24'h00ABCE))});
    chk(rx0[7:0], {even_bits(pat(24'h00ABCD)), even_bits(pat(24'h00ABCE))});
    stop_test();
  end
endmodule : flash_status_read_engine_tb
